// ==== logic/lwn_defs.svh ====
// lwn_defs.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from the wake notifier design files
`ifndef LWN_DEFS_SVH
`define LWN_DEFS_SVH

`define LWN_CLK_NS          20
`define LWN_PCLK_DIV        2
`define LWN_WAKE_PERIOD_PCLK 8
`define LWN_PWR_STOP_MS     167
`define LWN_PWR_STOP_CYC    ((`LWN_PWR_STOP_MS * 1000000) / `LWN_CLK_NS)
`define LWN_ACT_WIN_PCLK    4
`define LWN_PWR_CLASS_MAX   3'h4

`define LWN_REG_CTRL        8'h00
`define LWN_REG_FLAGS       8'h04
`define LWN_REG_STATUS      8'h08
`define LWN_REG_MASK        8'h0c
`define LWN_REG_PMCSR       8'h48

`define LWN_CTRL_LINK_CTRL  0
`define LWN_CTRL_RESUMING_PORT_IRQ_ENABLE       1
`define LWN_CTRL_PCLASS_LO  4
`define LWN_FLG_PEI         0
`define LWN_FLG_CONFIG_TIMEOUT_FLAG        1
`define LWN_FLG_CABLE_POWER_STATUS_FLAG        2
`define LWN_FLG_STATE_TIMEOUT_FLAG        3
`define LWN_ST_WAKE_ON      0
`define LWN_ST_LINK_WAKE    1
`define LWN_ST_PWR_STOP     2
`define LWN_POWER_EVENT_STATUS_FLAG_BIT     15
`define LWN_CTRL_RST        32'h0000_0000

`endif

// ==== logic/lwn_pkg.sv ====
// lwn_pkg.sv: types shared by the wake notifier files
// assumes: lwn_defs.svh supplies the numbers
package lwn_pkg;
  // last member is bit 0, matching the flag positions of the register
  typedef struct packed {
    logic state_timeout;
    logic cable_power;
    logic cfg_timeout;
    logic port_event;
  } lwn_flags_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } lwn_apb_rsp_t;

  typedef enum logic [1:0] {LWN_IDLE, LWN_PKT, LWN_INT, LWN_PWR} lwn_cause_t;
endpackage

// ==== logic/lwn_wake_sense.sv ====
// lwn_wake_sense.sv: link-side sampling of the wake pin
// assumes: wake pin is asynchronous to clk_sys
`timescale 1ns/1ps
`include "lwn_defs.svh"
module lwn_wake_sense
  import lwn_pkg::*;
#(
  parameter int WIN = `LWN_ACT_WIN_PCLK * `LWN_PCLK_DIV * `LWN_WAKE_PERIOD_PCLK
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic wake_in,
  output logic      active
);
  logic       s1_q;
  logic       s2_q;
  logic       s3_q;
  logic [7:0] win_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= wake_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // any edge or a high pin reloads the window; active while edges keep coming or the pin stays high
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      win_q <= 8'h00;
    end else if (s2_q != s3_q || s2_q) begin // [RULE16]
      win_q <= WIN[7:0];
    end else if (win_q != 8'h00) begin
      win_q <= win_q - 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      active <= 1'b0;
    end else begin
      active <= (win_q != 8'h00);
    end
  end

  wake_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (s2_q != s3_q) |-> ##2 active) // [RULE16]
    else $error("wake edge not reported active");
endmodule // lwn_wake_sense

// ==== logic/lwn_notifier.sv ====
// lwn_notifier.sv: link-on wake notifier, phy section and link-side sensing
// assumes: apb master on clk_sys; link_clock and serial lines from outside
//
// Summary of operation
// [RULE1] while active the wake output toggles with a period of eight phy clock cycles.
// [RULE2] inactive the wake output is driven low, and undriven while reset is held.
// [RULE3] the notification starts only while the link is inactive and a wake cause holds.
// [RULE4] a link-on packet addressed to this node is a wake cause.
// [RULE5] a set port event flag is a wake cause.
// [RULE6] config timeout, cable power or state timeout flags wake only with the resume enable set.
// [RULE7] a phy power cycle wakes when the power class is 0 to 4.
// [RULE8] once started the notification runs until link power status and link control are both set.
// [RULE9] a bus reset stops a notification caused only by a link-on packet.
// [RULE10] a notification raised by power cycle stops after 167 ms without link activity.
// [RULE11] a cause pending while the link is active starts the notification when it goes inactive; packet and power causes are cleared while it is active.
// [RULE12] the link-side wake input counts only while link power status is disabled.
// [RULE13] a wake seen then sets the power event status flag, bit 15 of the register at 48h.
// [RULE14] status goes to the link serially, timed by the phy clock.
// [RULE15] the link requests service serially, timed by the link clock.
// [RULE16] the link side synchronises the wake pin and treats recent toggling as active.
`timescale 1ns/1ps
`include "lwn_defs.svh"
module lwn_notifier
  import lwn_pkg::*;
#(
  parameter int PWR_STOP_CYC = `LWN_PWR_STOP_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        link_power_status,
  input  wire logic        link_on_packet,
  input  wire logic        bus_reset,
  input  wire logic        power_cycle,
  input  wire lwn_flags_t  flag_set,
  input  wire logic        link_clock,
  input  wire logic        phy_request_serial_in,
  input  wire logic        link_wake_notify_in,
  output logic             phy_wake_notify_out,
  output logic             phy_wake_notify_oe,
  output logic             phy_status_serial_out,
  output logic             irq
);
  localparam int PCNT_W = 24;

  lwn_apb_rsp_t rsp_q;
  lwn_flags_t   flags_q;
  lwn_cause_t   cause_q;
  logic [31:0]  ctrl_q;
  logic [2:0]   status_q;
  logic [2:0]   mask_q;
  logic         power_event_status_flag_q;
  logic         oe_q;
  logic         wake_q;
  logic         pkt_q;
  logic         pwr_q;
  logic [24:0]  pwr_cnt_q;
  logic [1:0]   div_q;
  logic [1:0]   half_q;
  logic         pclk_en;
  logic         lps_s1_q, lps_s2_q;
  logic         req_s1_q, req_s2_q;
  logic         lck_s1_q, lck_s2_q, lck_s3_q;
  logic         req_bit_q;
  logic         link_active;
  logic         int_cause;
  logic         pwr_ok;
  logic         any_cause;
  logic         link_wake_seen;
  logic         wr_en;
  logic         rd_en;
  logic         stat_q;

  function automatic logic sel(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  // pins from outside pass two flops; the link clock passes a third for edge detection
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lps_s1_q <= 1'b0;
      lps_s2_q <= 1'b0;
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      lck_s1_q <= 1'b0;
      lck_s2_q <= 1'b0;
      lck_s3_q <= 1'b0;
    end else begin
      lps_s1_q <= link_power_status;
      lps_s2_q <= lps_s1_q;
      req_s1_q <= phy_request_serial_in;
      req_s2_q <= req_s1_q;
      lck_s1_q <= link_clock;
      lck_s2_q <= lck_s1_q;
      lck_s3_q <= lck_s2_q;
    end
  end

  // request line sampled on link clock rising edges
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      req_bit_q <= 1'b0;
    end else if (lck_s2_q && !lck_s3_q) begin // [RULE15]
      req_bit_q <= req_s2_q;
    end
  end

  // phy clock enable derived from clk_sys
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 2'h0;
    end else begin
      div_q <= (div_q == 2'(`LWN_PCLK_DIV - 1)) ? 2'h0 : div_q + 2'h1;
    end
  end
  assign pclk_en = (div_q == 2'h0);

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `LWN_CTRL_RST;
      mask_q <= 3'h0;
    end else if (wr_en) begin
      if (sel(paddr, `LWN_REG_CTRL)) begin
        ctrl_q <= pwdata;
      end
      if (sel(paddr, `LWN_REG_MASK)) begin
        mask_q <= pwdata[2:0];
      end
    end
  end

  // interrupt flags of the phy: hardware set wins over software clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= '0;
    end else if (wr_en && sel(paddr, `LWN_REG_FLAGS)) begin
      flags_q <= lwn_flags_t'((flags_q & ~pwdata[3:0]) | flag_set);
    end else begin
      flags_q <= lwn_flags_t'(flags_q | flag_set);
    end
  end

  assign link_active = lps_s2_q && ctrl_q[`LWN_CTRL_LINK_CTRL]; // [RULE8]
  assign int_cause   = flags_q.port_event // [RULE5]
                     || (ctrl_q[`LWN_CTRL_RESUMING_PORT_IRQ_ENABLE] && (flags_q.cfg_timeout
                     || flags_q.cable_power || flags_q.state_timeout)); // [RULE6]
  assign pwr_ok      = ctrl_q[`LWN_CTRL_PCLASS_LO +: 3] <= `LWN_PWR_CLASS_MAX; // [RULE7]

  // packet and power causes are latched; interrupt cause is a level
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pkt_q <= 1'b0;
    end else if (link_active || bus_reset) begin // [RULE9]
      pkt_q <= 1'b0;
    end else if (link_on_packet) begin // [RULE4]
      pkt_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pwr_q     <= 1'b0;
      pwr_cnt_q <= 25'h0;
    end else if (link_active) begin
      pwr_q     <= 1'b0;
      pwr_cnt_q <= 25'h0;
    end else if (power_cycle && pwr_ok) begin // [RULE7]
      pwr_q     <= 1'b1;
      pwr_cnt_q <= 25'(PWR_STOP_CYC);
    end else if (pwr_q) begin
      pwr_cnt_q <= pwr_cnt_q - 25'h1;
      if (pwr_cnt_q == 25'h1) begin // [RULE10]
        pwr_q <= 1'b0;
      end
    end
  end

  assign any_cause = pkt_q || int_cause || pwr_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cause_q <= LWN_IDLE;
    end else begin
      case (1'b1)
        link_active: cause_q <= LWN_IDLE; // [RULE8]
        int_cause:   cause_q <= LWN_INT;  // [RULE11]
        pwr_q:       cause_q <= LWN_PWR;
        pkt_q:       cause_q <= LWN_PKT;
        default:     cause_q <= LWN_IDLE;
      endcase
    end
  end

  // square wave: toggle every four phy clock enables
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wake_q <= 1'b0;
      half_q <= 2'h0;
    end else if (!any_cause || link_active) begin // [RULE3]
      wake_q <= 1'b0;
      half_q <= 2'h0;
    end else if (pclk_en) begin
      half_q <= half_q + 2'h1;
      if (half_q == 2'(`LWN_WAKE_PERIOD_PCLK / 2 - 1)) begin // [RULE1]
        wake_q <= !wake_q;
      end
    end
  end

  // pin undriven in reset, driven afterwards
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= 1'b1; // [RULE2]
    end
  end
  assign phy_wake_notify_out = wake_q;
  assign phy_wake_notify_oe  = oe_q;

  // serial status: interrupt cause xor sampled request bit, updated on phy clock
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= 1'b0;
    end else if (pclk_en) begin // [RULE14]
      stat_q <= int_cause ^ req_bit_q;
    end
  end
  assign phy_status_serial_out = stat_q;

  lwn_wake_sense u_sense (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wake_in (link_wake_notify_in),
    .active  (link_wake_seen)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      power_event_status_flag_q <= 1'b0;
    end else if (link_wake_seen && !lps_s2_q) begin // [RULE12] [RULE13]
      power_event_status_flag_q <= 1'b1;
    end else if (wr_en && sel(paddr, `LWN_REG_PMCSR) && pwdata[`LWN_POWER_EVENT_STATUS_FLAG_BIT]) begin
      power_event_status_flag_q <= 1'b0;
    end
  end

  // sticky events: wake start, link wake seen, power-cycle stop
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= 3'h0;
    end else begin
      status_q <= (status_q & ~((wr_en && sel(paddr, `LWN_REG_STATUS)) ? pwdata[2:0] : 3'h0))
                | {pwr_q && pwr_cnt_q == 25'h1, power_event_status_flag_q, wake_q};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_q & mask_q);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rsp_q <= '0;
    end else begin
      rsp_q.pready  <= psel && !penable;
      rsp_q.pslverr <= 1'b0;
      rsp_q.prdata  <= 32'h0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `LWN_REG_CTRL:   rsp_q.prdata <= ctrl_q;
          `LWN_REG_FLAGS:  rsp_q.prdata <= {28'h0, flags_q};
          `LWN_REG_STATUS: rsp_q.prdata <= {29'h0, status_q};
          `LWN_REG_MASK:   rsp_q.prdata <= {29'h0, mask_q};
          `LWN_REG_PMCSR:  rsp_q.prdata <= {16'h0, power_event_status_flag_q, 15'h0};
          default:         rsp_q.pslverr <= 1'b1;
        endcase
      end else if (psel && !penable) begin
        rsp_q.pslverr <= !(sel(paddr, `LWN_REG_CTRL) || sel(paddr, `LWN_REG_FLAGS)
                        || sel(paddr, `LWN_REG_STATUS) || sel(paddr, `LWN_REG_MASK)
                        || sel(paddr, `LWN_REG_PMCSR));
      end
    end
  end
  assign prdata  = rsp_q.prdata;
  assign pready  = rsp_q.pready;
  assign pslverr = rsp_q.pslverr;

  wake_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (link_active ##1 link_active) |-> ##1 !wake_q) // [RULE8]
    else $error("wake output not low with link active");
  wake_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(wake_q) |-> $past(any_cause) && !$past(link_active)) // [RULE3]
    else $error("wake output started without cause");
  wake_period_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($rose(wake_q) ##1 (any_cause && !link_active)[*7]) |-> $stable(wake_q)) // [RULE1]
    else $error("wake half period too short");
  pkt_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bus_reset |=> !pkt_q) // [RULE9]
    else $error("packet cause survived bus reset");
  port_evt_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (flags_q.port_event && !link_active && pclk_en) |=> $changed(half_q)) // [RULE5]
    else $error("port event not a wake cause");
  int_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cause_q == LWN_INT && int_cause && bus_reset && !wr_en) |=> any_cause) // [RULE9]
    else $error("bus reset stopped an interrupt wake");
  pme_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (link_wake_seen && !lps_s2_q) |=> power_event_status_flag_q) // [RULE13]
    else $error("power event status not set");
  pwr_stop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pwr_q && pwr_cnt_q == 25'h1 && !link_active && !power_cycle) |=> !pwr_q) // [RULE10]
    else $error("power cycle wake did not stop");
  oe_on_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n) |-> phy_wake_notify_oe) // [RULE2]
    else $error("wake pin not driven after reset");
endmodule // lwn_notifier

// ==== test/lwn_link_model.sv ====
// lwn_link_model.sv: link-layer section as seen from the phy side of the wake pin
// assumes: bench decides power status and whether the link clock runs
`timescale 1ns/1ps
module lwn_link_model
  import lwn_pkg::*;
(
  input  wire logic lclk_en,
  input  wire logic lps_set,
  input  wire logic wake_out,
  input  wire logic wake_oe,
  output logic      link_clock,
  output logic      link_power_status,
  output logic      phy_request_serial_in,
  output logic      link_wake_notify_in
);
  logic [7:0] req_q = 8'h65;

  // 160 ns link clock, phase unrelated to clk_sys
  initial begin
    link_clock = 1'b0;
    #7;
    forever #80 link_clock = lclk_en & ~link_clock;
  end

  // request bits change on the falling edge so the phy samples them stable on the rise
  always @(negedge link_clock) begin
    req_q <= {req_q[6:0], req_q[7]};
  end

  assign phy_request_serial_in = req_q[7];
  assign link_power_status     = lps_set;
  // pull-down resistor holds the released pin low
  assign link_wake_notify_in   = wake_oe ? wake_out : 1'b0;
endmodule // lwn_link_model

// ==== test/tb_top.sv ====
// tb_top.sv: self-checking bench for the wake notifier over apb
// assumes: lwn_link_model stands on the link side of the wake pin
`timescale 1ns/1ps
`include "lwn_defs.svh"
module tb_top
  import lwn_pkg::*;
;
  localparam int STOP_CYC = 50;
  logic        clk_sys, rst_n, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic        pready, pslverr, rerr, irq;
  logic        link_on_packet, bus_reset, power_cycle, lclk_en, lps_set;
  logic        link_clock, link_power_status, phy_request_serial_in;
  logic        link_wake_notify_in, phy_wake_notify_out, phy_wake_notify_oe;
  logic        phy_status_serial_out;
  lwn_flags_t  flag_set;
  int          miscompares, cmp_count, e;

  lwn_notifier #(.PWR_STOP_CYC(STOP_CYC)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_power_status(link_power_status),
    .link_on_packet(link_on_packet), .bus_reset(bus_reset),
    .power_cycle(power_cycle), .flag_set(flag_set), .link_clock(link_clock),
    .phy_request_serial_in(phy_request_serial_in),
    .link_wake_notify_in(link_wake_notify_in),
    .phy_wake_notify_out(phy_wake_notify_out), .phy_wake_notify_oe(phy_wake_notify_oe),
    .phy_status_serial_out(phy_status_serial_out), .irq(irq));

  lwn_link_model i_link (
    .lclk_en(lclk_en), .lps_set(lps_set), .wake_out(phy_wake_notify_out),
    .wake_oe(phy_wake_notify_oe), .link_clock(link_clock),
    .link_power_status(link_power_status), .phy_request_serial_in(phy_request_serial_in),
    .link_wake_notify_in(link_wake_notify_in));

  always #10 clk_sys = ~clk_sys;

  task report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // request held until the rising edge that samples pready high; answer taken there
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk_sys);
    end
    if (n >= 20) miscompares++;
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task set_flag(input logic [3:0] f);
    @(posedge clk_sys);
    flag_set <= lwn_flags_t'(f);
    @(posedge clk_sys);
    flag_set <= '0;
    repeat (4) @(posedge clk_sys);
  endtask

  // number of level changes of the serial status line over cyc cycles
  task count_stat(input int cyc);
    logic prev;
    e = 0;
    @(negedge clk_sys);
    prev = phy_status_serial_out;
    repeat (cyc) begin
      @(negedge clk_sys);
      if (phy_status_serial_out !== prev) e++;
      prev = phy_status_serial_out;
    end
  endtask

  task pulse(input int k);
    @(posedge clk_sys);
    case (k)
      0: link_on_packet <= 1'b1;
      1: bus_reset <= 1'b1;
      default: power_cycle <= 1'b1;
    endcase
    @(posedge clk_sys);
    link_on_packet <= 1'b0; bus_reset <= 1'b0; power_cycle <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  task set_lps(input logic v);
    @(posedge clk_sys);
    lps_set <= v;
    repeat (8) @(posedge clk_sys);
  endtask

  // number of level changes of the wake pin over cyc cycles
  task count_edges(input int cyc);
    logic prev;
    e = 0;
    @(negedge clk_sys);
    prev = phy_wake_notify_out;
    repeat (cyc) begin
      @(negedge clk_sys);
      if (phy_wake_notify_out !== prev) e++;
      prev = phy_wake_notify_out;
    end
  endtask

  initial begin
    #300000;
    miscompares++;
    report_and_stop;
  end

  initial begin
    clk_sys = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; link_on_packet = 1'b0; bus_reset = 1'b0;
    power_cycle = 1'b0; lclk_en = 1'b1; lps_set = 1'b0; flag_set = '0;
    miscompares = 0; cmp_count = 0;
    repeat (6) @(posedge clk_sys);
    check({31'h0, phy_wake_notify_oe}, 32'h0);
    rst_n <= 1'b1;
    repeat (3) @(negedge clk_sys);
    check({30'h0, phy_wake_notify_oe, phy_wake_notify_out}, 32'h2);
    xfer(1'b0, `LWN_REG_CTRL, 32'h0);
    check(rdata, `LWN_CTRL_RST);
    xfer(1'b0, `LWN_REG_FLAGS, 32'h0);
    check(rdata, 32'h0);
    xfer(1'b0, `LWN_REG_STATUS, 32'h0);
    check(rdata, 32'h0);
    xfer(1'b1, 8'h20, 32'hffff_ffff);
    check({31'h0, rerr}, 32'h1);
    xfer(1'b0, 8'h20, 32'h0);
    check({31'h0, rerr}, 32'h1);
    // request pattern 01100101 repeats every 64 cycles with six level changes
    count_stat(64);
    check(32'(e), 32'd6);
    // packet wake with link power status off
    pulse(0);
    count_edges(64);
    check(32'(e), 32'd8);
    xfer(1'b0, `LWN_REG_PMCSR, 32'h0);
    check(rdata & 32'h8000, 32'h8000);
    pulse(1);
    count_edges(64);
    check(32'(e), 32'd0);
    check({31'h0, phy_wake_notify_out}, 32'h0);
    // link fully active: no start, power event status stays clear
    xfer(1'b1, `LWN_REG_CTRL, 32'h1);
    set_lps(1'b1);
    xfer(1'b1, `LWN_REG_PMCSR, 32'h8000);
    pulse(0);
    count_edges(64);
    check(32'(e), 32'd0);
    xfer(1'b0, `LWN_REG_PMCSR, 32'h0);
    check(rdata & 32'h8000, 32'h0);
    pulse(1);
    // control bit set but power status off is still inactive; then both set stops it
    set_lps(1'b0);
    pulse(0);
    count_edges(64);
    check(32'(e), 32'd8);
    set_lps(1'b1);
    count_edges(64);
    check(32'(e), 32'd0);
    // power status on but control bit clear is inactive as well
    xfer(1'b1, `LWN_REG_CTRL, 32'h0);
    pulse(0);
    count_edges(64);
    check(32'(e), 32'd8);
    pulse(1);
    set_lps(1'b0);
    repeat (64) @(posedge clk_sys);
    // sticky status drives irq only through the mask
    xfer(1'b1, `LWN_REG_MASK, 32'h1);
    repeat (2) @(negedge clk_sys);
    check({31'h0, irq}, 32'h1);
    xfer(1'b1, `LWN_REG_MASK, 32'h0);
    repeat (2) @(negedge clk_sys);
    check({31'h0, irq}, 32'h0);
    // power event status still set from the earlier wake would re-set status bit 1
    xfer(1'b1, `LWN_REG_PMCSR, 32'h8000);
    xfer(1'b1, `LWN_REG_STATUS, 32'h7);
    xfer(1'b0, `LWN_REG_STATUS, 32'h0);
    check(rdata, 32'h0);
    xfer(1'b1, `LWN_REG_MASK, 32'h1);
    repeat (2) @(negedge clk_sys);
    check({31'h0, irq}, 32'h0);
    // interrupt flags: port event alone, the others only with resume enable
    set_flag(4'h1 << `LWN_FLG_PEI);
    count_edges(64);
    check(32'(e), 32'd8);
    pulse(1);
    count_edges(64);
    check(32'(e), 32'd8);
    xfer(1'b0, `LWN_REG_FLAGS, 32'h0);
    check(rdata, 32'h1 << `LWN_FLG_PEI);
    xfer(1'b1, `LWN_REG_FLAGS, 32'hf);
    repeat (4) @(posedge clk_sys);
    count_edges(64);
    check(32'(e), 32'd0);
    set_flag((4'h1 << `LWN_FLG_CONFIG_TIMEOUT_FLAG) | (4'h1 << `LWN_FLG_CABLE_POWER_STATUS_FLAG) | (4'h1 << `LWN_FLG_STATE_TIMEOUT_FLAG));
    count_edges(64);
    check(32'(e), 32'd0);
    xfer(1'b1, `LWN_REG_CTRL, 32'h1 << `LWN_CTRL_RESUMING_PORT_IRQ_ENABLE);
    repeat (4) @(posedge clk_sys);
    count_edges(64);
    check(32'(e), 32'd8);
    // cause pending while the link is active starts the wave once it goes inactive
    xfer(1'b1, `LWN_REG_CTRL, (32'h1 << `LWN_CTRL_RESUMING_PORT_IRQ_ENABLE) | 32'h1);
    set_lps(1'b1);
    count_edges(64);
    check(32'(e), 32'd0);
    set_lps(1'b0);
    count_edges(64);
    check(32'(e), 32'd8);
    xfer(1'b1, `LWN_REG_FLAGS, 32'hf);
    // power cycle wakes for class 0 to 4 and stops on its own
    for (int c = 0; c < 6; c++) begin
      xfer(1'b1, `LWN_REG_CTRL, 32'(c) << `LWN_CTRL_PCLASS_LO);
      xfer(1'b1, `LWN_REG_STATUS, 32'h7);
      pulse(2);
      count_edges(32);
      check(32'(e), (c <= 4) ? 32'd4 : 32'd0);
      repeat (STOP_CYC) @(posedge clk_sys);
      count_edges(32);
      check(32'(e), 32'd0);
      xfer(1'b0, `LWN_REG_STATUS, 32'h0);
      check(rdata & 32'h4, (c <= 4) ? 32'h4 : 32'h0);
    end
    report_and_stop;
  end
endmodule // tb_top
